/* File: dv/afcr_top_monitor.sv */
// Checker for the auxiliary control bank
`timescale 1ns/100ps
module afcr_top_monitor (
    input wire       clk,
    input wire       rst_n,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata_r,
    input wire [7:0] rpt_ctrl_r,
    input wire       dac_out_r,
    input wire       dac_oe_r,
    input wire       tone_out_r
);
reg  [7:0] hi_r, lo_r;
wire [2:0] m = hi_r[7:5];
wire       z = (m == 3'h6) && ({hi_r[3:0], lo_r} == 12'h000);
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        hi_r <= 8'ha2;
        lo_r <= 8'h00;
    end else if (reg_wr && reg_addr == 8'h06) hi_r <= reg_wdata;
    else if (reg_wr && reg_addr == 8'h07) lo_r <= reg_wdata;
end
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
////////////////////////////////////////////////////////////////
a_mode_low: assert property ($past(m) == 3'h0 && $past(m, 2) == 3'h0 |-> dac_oe_r && !dac_out_r)
    else $error("pin not low");
a_mode_high: assert property ($past(m) == 3'h1 && $past(m, 2) == 3'h1 |-> dac_oe_r && dac_out_r)
    else $error("pin not high");
a_mode_hiz: assert property ($past(m) == 3'h2 && $past(m, 2) == 3'h2 |-> !dac_oe_r)
    else $error("pin driven");
a_pdm_drive: assert property ($past(rst_n) && $past(m) inside {4, 5, 6} && $past(m, 2) == $past(m)
    |-> dac_oe_r) else $error("pin not driven");
a_div16_hold: assert property ($changed(dac_out_r) && m == 3'h4 && $past(m, 2) == 3'h4
    |=> (m != 3'h4 || $stable(dac_out_r)) [*8]) else $error("step too fast");
a_zero_code: assert property ($past(z) && $past(z, 2) && $past(z, 3) && $past(z, 4) |-> !dac_out_r)
    else $error("zero code pulses");
a_rpt_write: assert property (reg_wr && reg_addr == 8'h05 |=> rpt_ctrl_r == $past(reg_wdata))
    else $error("repeater write lost");
a_rd_unmapped: assert property (reg_rd && !(reg_addr inside {[4:7]}) |=> reg_rdata_r == 8'h00)
    else $error("unmapped read");
a_rd_rpt: assert property (reg_rd && reg_addr == 8'h05 |=> reg_rdata_r == $past(rpt_ctrl_r))
    else $error("repeater read");
c_div16: cover property ($changed(dac_out_r) && m == 3'h4);
c_zero: cover property (z);
c_hiz: cover property (m == 3'h2 && !dac_oe_r);
endmodule // afcr_top_monitor
bind afcr_top afcr_top_monitor i_afcr_top_monitor (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
    .rpt_ctrl_r(rpt_ctrl_r), .dac_out_r(dac_out_r), .dac_oe_r(dac_oe_r), .tone_out_r(tone_out_r));

/* File: dv/aux_frontend_control_regs_test.sv */
// Self-checking bench for the auxiliary control bank
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; $display("mismatch %0t %h %h", $time, a, b); end end
module aux_frontend_control_regs_test;
reg        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
reg  [7:0] reg_addr = 0, reg_wdata = 0, d, e;
reg [11:0] c;
wire [7:0] reg_rdata_r, rpt_ctrl_r;
wire       dac_out_r, dac_oe_r, tone_out_r;
int        err_total = 0, num_checks = 0, i, n, t, k;
afcr_top i_afcr_top (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .rpt_ctrl_r(rpt_ctrl_r), .dac_out_r(dac_out_r),
    .dac_oe_r(dac_oe_r), .tone_out_r(tone_out_r));
initial forever #20 clk = ~clk;
////////////////////////////////////////////////////////////////
function [7:0] rv(input int a);
    rv = a == 4 ? 8'h8e : a == 5 ? 8'h0f : a == 6 ? 8'ha2 : 8'h00;
endfunction
task end_sim;
    if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
endtask
task wr(input [7:0] a, input [7:0] v);
    @(posedge clk); #1 reg_wr = 1; reg_addr = a; reg_wdata = v;
    @(posedge clk); #1 reg_wr = 0;
endtask
task rd(input [7:0] a, output [7:0] v);
    @(posedge clk); #1 reg_rd = 1; reg_addr = a;
    @(posedge clk); #1 reg_rd = 0; v = reg_rdata_r;
endtask
task meas;
    repeat (40) @(posedge clk);
    n = 0; t = 0; e = 0;
    repeat (4096) begin @(posedge clk); #1 n += dac_out_r; t += (dac_out_r !== e[0]); e[0] = dac_out_r; end
endtask
task tog(output int q);
    reg v;
    v = tone_out_r; q = 0;
    while (tone_out_r === v) begin @(posedge clk); #1 q++; if (q > 2000) begin err_total++; end_sim; end end
endtask
////////////////////////////////////////////////////////////////
initial begin
    void'($urandom(32'h8284));
    repeat (5) @(posedge clk);
    #1 rst_n = 1;
    `CHK(rpt_ctrl_r, 8'h0f)
    for (i = 3; i < 9; i++) begin rd(8'(i), d); `CHK(d, rv(i)) end
    for (i = 0; i < 8; i++) begin
        n = 4 + $urandom % 4; d = 8'($urandom);
        if (n == 6) d = {3'h6, 1'b0, d[3:0]};
        wr(8'(n), d); rd(8'(n), e); `CHK(e, d)
        if (n == 5) `CHK(rpt_ctrl_r, d)
    end
    for (i = 0; i < 3; i++) begin
        wr(8'h06, 8'(i << 5)); repeat (3) @(posedge clk); #1;
        `CHK(dac_oe_r, 1'(i != 2))
        if (i < 2) `CHK(dac_out_r, i[0])
    end
    wr(8'h07, 8'h00);
    for (i = 0; i < 3; i++) begin
        wr(8'h06, 8'h88 + 8'(i << 5)); meas; k = 16 >> (2 * i);
        `CHK(1'(n >= 2048 - k && n <= 2048 + k && t >= 4096 / k - 2 && t <= 4096 / k + 2), 1'b1)
    end
    for (i = 0; i < 2; i++) begin
        c = i ? 12'($urandom) : 12'h000;
        wr(8'h06, {3'h6, 1'b0, c[11:8]}); wr(8'h07, c[7:0]); meas;
        `CHK(1'(n >= int'(c) - 2 && n <= int'(c) + 2), 1'b1)
    end
    for (i = 0; i < 2; i++) begin
        d = i ? 8'(2 + $urandom % 4) : 8'h01;
        wr(8'h04, d); tog(k); tog(k); tog(k);
        `CHK(k, 16 * d)
    end
    end_sim;
end
endmodule // aux_frontend_control_regs_test

/* File: inc/afcr_regs.vh */
// Register offsets, reset values, field positions and mode codes of the auxiliary control bank
`ifndef AFCR_REGS_VH
`define AFCR_REGS_VH
`define AFCR_ADDR_TONE_DIV      8'h04
`define AFCR_ADDR_RPT_CTRL      8'h05
`define AFCR_ADDR_DAC_HIGH      8'h06
`define AFCR_ADDR_DAC_LOW       8'h07
`define AFCR_RST_TONE_DIV       8'h8e
`define AFCR_RST_RPT_CTRL       8'h0f
`define AFCR_RST_DAC_HIGH       8'ha2
`define AFCR_RST_DAC_LOW        8'h00
`define AFCR_MODE_MSB           7
`define AFCR_MODE_LSB           5
`define AFCR_DAC_RSVD_BIT       4
`define AFCR_MODE_LOW           3'h0
`define AFCR_MODE_HIGH          3'h1
`define AFCR_MODE_HIZ           3'h2
`define AFCR_MODE_DIV16         3'h4
`define AFCR_MODE_DIV4          3'h5
`define AFCR_MODE_DIV1          3'h6
`define AFCR_DIV16_CNT          4'hf
`define AFCR_DIV4_CNT           4'h3
`define AFCR_TONE_PRESCALE      4'hf
`endif

/* File: verilog/afcr_pdm.v */
// Pulse-density modulator core for the auxiliary DAC
`timescale 1ns/100ps
module afcr_pdm #(
    parameter WIDTH = 12
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             step_en,
    input  wire [WIDTH-1:0] code,
    output reg              pdm_out_r
);
    reg  [WIDTH-1:0] acc_r;
    wire [WIDTH:0]   sum = {1'b0, acc_r} + {1'b0, code};

    // First-order accumulator, carry gives high-time fraction of code/2^WIDTH
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_r     <= {WIDTH{1'b0}};
            pdm_out_r <= 1'b0;
        end else if (step_en) begin
            acc_r     <= sum[WIDTH-1:0];
            pdm_out_r <= sum[WIDTH];
        end
    end
endmodule // afcr_pdm

/* File: verilog/afcr_top.v */
// Auxiliary front-end control register bank with DAC and tone divider
//
// What this block does
// - Bits 7:5 of dac_control_high select the DAC pin function.
// - Mode 000 drives the DAC pin constantly low.
// - Mode 001 drives the DAC pin constantly high.
// - Mode 010 releases the DAC pin to high impedance.
// - Mode 100 modulates duty cycle at master clock divided by sixteen.
// - Mode 101 modulates duty cycle at master clock divided by four.
// - Mode 110 modulates duty cycle at full master clock rate.
`timescale 1ns/100ps
`include "afcr_regs.vh"
module afcr_top (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata_r,
    output reg  [7:0] rpt_ctrl_r,
    output reg        dac_out_r,
    output reg        dac_oe_r,
    output reg        tone_out_r
);
    ////////////////////////////////////////////////////////////////////////
    // Registers
    reg  [7:0] tone_div_r;
    reg  [7:0] dac_high_r;
    reg  [7:0] dac_low_r;
    reg  [3:0] pre_r;
    reg        tick_r;
    reg  [7:0] tone_cnt_r;
    reg  [3:0] rate_cnt_r;
    reg        step_r;
    reg  [7:0] rd_mux;
    reg  [3:0] rate_top;
    reg        rate_en;
    wire [2:0] mode     = dac_high_r[`AFCR_MODE_MSB:`AFCR_MODE_LSB];
    wire       pdm_bit;
    wire       hit_tone = (reg_addr == `AFCR_ADDR_TONE_DIV);
    wire       hit_rpt  = (reg_addr == `AFCR_ADDR_RPT_CTRL);
    wire       hit_high = (reg_addr == `AFCR_ADDR_DAC_HIGH);
    wire       hit_low  = (reg_addr == `AFCR_ADDR_DAC_LOW);

    ////////////////////////////////////////////////////////////////////////
    // Tone divider register
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tone_div_r <= `AFCR_RST_TONE_DIV;
        end else if (reg_wr && hit_tone) begin
            tone_div_r <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Repeater control register
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rpt_ctrl_r <= `AFCR_RST_RPT_CTRL;
        end else if (reg_wr && hit_rpt) begin
            rpt_ctrl_r <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // DAC control register: mode field and top four code bits
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dac_high_r <= `AFCR_RST_DAC_HIGH;
        end else if (reg_wr && hit_high) begin
            dac_high_r <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // DAC code register: low eight code bits
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dac_low_r <= `AFCR_RST_DAC_LOW;
        end else if (reg_wr && hit_low) begin
            dac_low_r <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read-back; a read together with a write returns the old value
    always @* begin
        rd_mux = 8'h00;
        case (reg_addr)
            `AFCR_ADDR_TONE_DIV: rd_mux = tone_div_r;
            `AFCR_ADDR_RPT_CTRL: rd_mux = rpt_ctrl_r;
            `AFCR_ADDR_DAC_HIGH: rd_mux = dac_high_r;
            `AFCR_ADDR_DAC_LOW:  rd_mux = dac_low_r;
            default:             rd_mux = 8'h00;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_r <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_r <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Modulation rate enable
    // Step pulse fires every 16, 4 or 1 clocks
    // Leaving a modulated mode parks the counter at zero
    always @* begin
        rate_top = 4'h0;
        rate_en  = 1'b0;
        case (mode)
            `AFCR_MODE_DIV16: begin
                rate_top = `AFCR_DIV16_CNT;
                rate_en  = 1'b1;
            end
            `AFCR_MODE_DIV4: begin
                rate_top = `AFCR_DIV4_CNT;
                rate_en  = 1'b1;
            end
            `AFCR_MODE_DIV1: begin
                rate_top = 4'h0;
                rate_en  = 1'b1;
            end
            default: begin
                rate_top = 4'h0;
                rate_en  = 1'b0;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_cnt_r <= 4'h0;
            step_r     <= 1'b0;
        end else if (!rate_en || rate_cnt_r >= rate_top) begin
            rate_cnt_r <= 4'h0;
            step_r     <= rate_en;
        end else begin
            rate_cnt_r <= rate_cnt_r + 4'h1;
            step_r     <= 1'b0;
        end
    end

    afcr_pdm #(
        .WIDTH (12)
    ) u_pdm (
        .clk       (clk),
        .rst_n     (rst_n),
        .step_en   (step_r),
        .code      ({dac_high_r[3:0], dac_low_r}),
        .pdm_out_r (pdm_bit)
    );

    ////////////////////////////////////////////////////////////////////////
    // DAC pin
    // Reserved mode codes release the pin like high impedance
    // Modulated modes drive the registered modulator bit
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dac_out_r <= 1'b0;
            dac_oe_r  <= 1'b0;
        end else begin
            case (mode)
                `AFCR_MODE_LOW: begin
                    dac_out_r <= 1'b0;
                    dac_oe_r  <= 1'b1;
                end
                `AFCR_MODE_HIGH: begin
                    dac_out_r <= 1'b1;
                    dac_oe_r  <= 1'b1;
                end
                `AFCR_MODE_HIZ: begin
                    dac_out_r <= 1'b0;
                    dac_oe_r  <= 1'b0;
                end
                `AFCR_MODE_DIV16, `AFCR_MODE_DIV4, `AFCR_MODE_DIV1: begin
                    dac_out_r <= pdm_bit;
                    dac_oe_r  <= 1'b1;
                end
                default: begin
                    dac_out_r <= 1'b0;
                    dac_oe_r  <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tone prescaler: one-cycle tick every sixteen clocks
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_r  <= 4'h0;
            tick_r <= 1'b0;
        end else if (pre_r == `AFCR_TONE_PRESCALE) begin
            pre_r  <= 4'h0;
            tick_r <= 1'b1;
        end else begin
            pre_r  <= pre_r + 4'h1;
            tick_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tone divider: toggled at each terminal count, zero acts as one
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tone_cnt_r <= 8'h00;
            tone_out_r <= 1'b0;
        end else if (tick_r) begin
            if (tone_cnt_r + 8'h01 >= tone_div_r) begin
                tone_cnt_r <= 8'h00;
                tone_out_r <= ~tone_out_r;
            end else begin
                tone_cnt_r <= tone_cnt_r + 8'h01;
            end
        end
    end
endmodule // afcr_top
